// ==== core/irq_ctrl_pkg.sv ====
// constants for the two-level interrupt control and flag register bank
package irq_ctrl_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_MAIN     = 8'h00;
	localparam logic [7:0] OFF_EDGES    = 8'h04;
	localparam logic [7:0] OFF_EXTPINS  = 8'h08;
	localparam logic [7:0] OFF_PFLAGS1  = 8'h0C;
	localparam logic [7:0] OFF_PFLAGS2  = 8'h10;
	localparam logic [7:0] OFF_CONFIG   = 8'h14;
	localparam logic [7:0] OFF_STATUS   = 8'h18;
	// main register fields
	localparam int B_GHIGH    = 7;
	localparam int B_PLOW     = 6;
	localparam int B_T0_EN    = 5;
	localparam int B_X0_EN    = 4;
	localparam int B_PC_EN    = 3;
	localparam int B_T0_FLAG  = 2;
	localparam int B_X0_FLAG  = 1;
	localparam int B_PC_FLAG  = 0;
	// edges / pull-up register fields
	localparam int B_PU_DIS   = 7;
	localparam int B_X0_EDGE  = 6;
	localparam int B_X1_EDGE  = 5;
	localparam int B_X2_EDGE  = 4;
	localparam int B_T0_PRIO  = 2;
	localparam int B_PC_PRIO  = 0;
	// external pin register fields
	localparam int B_X2_PRIO  = 7;
	localparam int B_X1_PRIO  = 6;
	localparam int B_X2_EN    = 4;
	localparam int B_X1_EN    = 3;
	localparam int B_X2_FLAG  = 1;
	localparam int B_X1_FLAG  = 0;
	// peripheral flags one: read-only bits
	localparam int B_RX_FULL  = 5;
	localparam int B_TX_EMPTY = 4;
	// config register: priority mode, then per-pin change enables, then pull-ups
	localparam int B_PRIO_MODE = 0;
	localparam int F_IOC_LO    = 8;
	localparam int F_WPU_LO    = 16;
	// reset values and writable masks
	localparam logic [7:0] RST_MAIN    = 8'h00;
	localparam logic [7:0] RST_EDGES   = 8'hF5;
	localparam logic [7:0] RST_EXTPINS = 8'hC0;
	localparam logic [7:0] MASK_EDGES  = 8'hF5;
	localparam logic [7:0] MASK_EXTPIN = 8'hDB;
	localparam logic [7:0] MASK_PF1    = 8'h4F;
	// vectors and response codes
	localparam logic [15:0] VEC_HIGH = 16'h0008;
	localparam logic [15:0] VEC_LOW  = 16'h0018;
	localparam logic [1:0]  RESP_OK     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// ==== core/edge_catch.sv ====
// selectable edge detector for one external interrupt pin
module edge_catch
(
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// pin and selection
	input  wire logic pin,
	input  wire logic rising,
	// detected edge, one-cycle pulse
	output logic      hit
);
	logic last;

	// follows the pin through reset too, so release shows no false edge
	always_ff @(posedge aclk)
	begin
		last <= pin;
	end

	// rising when selection is 1, falling when 0
	assign hit = aresetn && (rising ? (pin & ~last) : (~pin & last));
endmodule

// ==== core/change_catch.sv ====
// port change mismatch detector with a latch updated on port reads
module change_catch
(
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// upper port pins and per-pin enables
	input  wire logic [3:0] pins,
	input  wire logic [3:0] pin_en,
	input  wire logic       port_read,
	// mismatch state
	output logic            mismatch,
	output logic            enabled_mismatch
);
	logic [3:0] latched;

	// a port read copies the pins and so ends the mismatch; reset copies them too
	always_ff @(posedge aclk)
	begin
		if (!aresetn || port_read)
			latched <= pins;
	end

	assign mismatch         = |(pins ^ latched);
	assign enabled_mismatch = |((pins ^ latched) & pin_en);
endmodule

// ==== core/two_level_interrupt_control.sv ====
// interrupt control and flag register bank with high and low priority requests
// Notes on behaviour
// - compatibility mode: top global bit enables unmasked interrupts, clear blocks everything
// - priority mode: top global bit enables high ones, clear blocks all
// - compatibility mode: second global bit gates peripheral interrupts
// - priority mode: second global bit gates low priority interrupts
// - flags set on their events regardless of any enable
// - port change flag sets on upper pin change; mismatch persists until port read
// - port change request also needs the pin's own change enable
// - external edge selects: 1 rising, 0 falling, reset to 1
// - priority bits: 1 high, 0 low, reset to 1
// - pull-up disable bit kills all pull-ups; else input pins with enable
// - timer0 overflow flag sticky until cleared, gated by its enable
// - external flags set on selected edge, sticky, own enables
// - receive flag read-only, high while receive buffer holds data
// - transmit flag read-only, high while transmit buffer empty
// - capture/compare flags set on capture or match, cleared by software
// - timer2 match and timer1/timer3 overflow flags, cleared by software
// - oscillator fail flag set on failover, cleared by software
// - comparator flags set on output change, cleared by software
// - nonvolatile write flag set on write completion, cleared by software
// - sync port done and collision flags, cleared by software
// - conversion done flag and low-voltage flag in chosen direction
// - priority mode follows the priority enable bit, clear by default
// - requests vector high or low by priority; compatibility uses high
// - on response the relevant global bit clears; high preempts low only
// - external interrupt 0 is always high priority
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
module two_level_interrupt_control
	import irq_ctrl_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address and data
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// source events, one-cycle pulses
	input  wire logic        timer0_overflow,
	input  wire logic        timer1_overflow,
	input  wire logic        timer2_match,
	input  wire logic        timer3_overflow,
	input  wire logic        capcomp1_event,
	input  wire logic        capcomp2_event,
	input  wire logic        conversion_done,
	input  wire logic        sync_port1_done,
	input  wire logic        sync_port1_collision,
	input  wire logic        nv_write_done,
	input  wire logic        osc_fail,
	input  wire logic        low_voltage_event,
	// source levels
	input  wire logic        comparator1_out,
	input  wire logic        comparator2_out,
	input  wire logic        serial1_rx_full,
	input  wire logic        serial1_tx_empty,
	input  wire logic [2:0]  ext_pins,
	input  wire logic [3:0]  portb_upper,
	input  wire logic        portb_read,
	input  wire logic [7:0]  portb_is_input,
	// core interface
	input  wire logic        irq_ack_high,
	input  wire logic        irq_ack_low,
	input  wire logic        irq_return,
	output logic             irq_high,
	output logic             irq_low,
	output logic [15:0]      irq_vector,
	output logic [7:0]       portb_pullup_on
);
	import irq_ctrl_pkg::*;

	logic [7:0] main_reg, edges_reg, ext_reg, pf1_reg, pf2_reg;
	logic       priority_mode_enable;
	logic [3:0] per_pin_change_enable;
	logic [7:0] per_pin_pullup_enable;
	logic       cmp1_last, cmp2_last;
	logic       in_high, in_low;
	logic       aw_held, w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic       wr_go;
	logic [2:0] x_hit;
	logic       pc_mismatch, pc_enabled;
	logic       global_high_enable, peripheral_low_enable;
	logic       cmp1_chg, cmp2_chg;
	logic [7:0] pf2_evt, pf1_evt;
	logic       wr_main, wr_edges, wr_ext, wr_pf1, wr_pf2, wr_cfg;
	logic [7:0] wbyte;
	logic [7:0] pie1, pie2;
	logic       hi_src, lo_src, periph_pend, core_pend, compat_req;
	logic       next_irq_high, next_irq_low;

	// one-hot address decode, shared by write and read sides
	function automatic logic hit_at(input logic [7:0] a, input logic [7:0] off);
		hit_at = (a[7:2] == off[7:2]);
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_ext
			edge_catch u_edge
			(
				.aclk    (aclk),
				.aresetn (aresetn),
				.pin     (ext_pins[gi]),
				.rising  (edges_reg[B_X0_EDGE - gi]),
				.hit     (x_hit[gi])
			);
		end
	endgenerate

	change_catch u_change
	(
		.aclk             (aclk),
		.aresetn          (aresetn),
		.pins             (portb_upper),
		.pin_en           (per_pin_change_enable),
		.port_read        (portb_read),
		.mismatch         (pc_mismatch),
		.enabled_mismatch (pc_enabled)
	);

	// ---- axi4-lite write: address and data taken in either order
	assign wr_go = aw_held && w_held && !s_axi_bvalid;
	assign wbyte = w_data[7:0];
	assign wr_main  = wr_go && w_strb[0] && hit_at(aw_addr, OFF_MAIN);
	assign wr_edges = wr_go && w_strb[0] && hit_at(aw_addr, OFF_EDGES);
	assign wr_ext   = wr_go && w_strb[0] && hit_at(aw_addr, OFF_EXTPINS);
	assign wr_pf1   = wr_go && w_strb[0] && hit_at(aw_addr, OFF_PFLAGS1);
	assign wr_pf2   = wr_go && w_strb[0] && hit_at(aw_addr, OFF_PFLAGS2);
	assign wr_cfg   = wr_go && hit_at(aw_addr, OFF_CONFIG);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OK;
		end
		else
		begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr[7:2] > OFF_STATUS[7:2]) ? RESP_SLVERR : RESP_OK;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ---- configuration bits outside the documented registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			priority_mode_enable  <= 1'b0;
			per_pin_change_enable <= 4'h0;
			per_pin_pullup_enable <= 8'h00;
		end
		else if (wr_cfg)
		begin
			if (w_strb[0])
				priority_mode_enable <= w_data[B_PRIO_MODE];
			if (w_strb[1])
				per_pin_change_enable <= w_data[F_IOC_LO +: 4];
			if (w_strb[2])
				per_pin_pullup_enable <= w_data[F_WPU_LO +: 8];
		end
	end

	// ---- priority bits and edge selects
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			edges_reg <= RST_EDGES;
		else if (wr_edges)
			edges_reg <= wbyte & MASK_EDGES;
	end

	// ---- main register: enables plus sticky flags; set beats software clear
	assign global_high_enable    = main_reg[B_GHIGH];
	assign peripheral_low_enable = main_reg[B_PLOW];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			main_reg <= RST_MAIN;
		else
		begin
			if (wr_main)
				main_reg <= wbyte;
			// the core's acknowledge drops the level that was taken
			if (irq_ack_high)
				main_reg[B_GHIGH] <= 1'b0;
			else if (irq_ack_low)
				main_reg[B_PLOW] <= 1'b0;
			if (irq_return)
			begin
				if (in_high || !priority_mode_enable)
					main_reg[B_GHIGH] <= 1'b1;
				else
					main_reg[B_PLOW] <= 1'b1;
			end
			if (timer0_overflow)
				main_reg[B_T0_FLAG] <= 1'b1;
			if (x_hit[0])
				main_reg[B_X0_FLAG] <= 1'b1;
			if (pc_mismatch)
				main_reg[B_PC_FLAG] <= 1'b1;
		end
	end

	// service nesting: high may preempt low, never the reverse
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			in_high <= 1'b0;
			in_low  <= 1'b0;
		end
		else if (irq_ack_high)
			in_high <= 1'b1;
		else if (irq_ack_low)
			in_low <= 1'b1;
		else if (irq_return)
		begin
			if (in_high)
				in_high <= 1'b0;
			else
				in_low <= 1'b0;
		end
	end

	// ---- external 1/2 priorities, enables and flags; set beats software clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ext_reg <= RST_EXTPINS;
		else
		begin
			if (wr_ext)
				ext_reg <= wbyte & MASK_EXTPIN;
			if (x_hit[1])
				ext_reg[B_X1_FLAG] <= 1'b1;
			if (x_hit[2])
				ext_reg[B_X2_FLAG] <= 1'b1;
		end
	end

	// ---- peripheral flags; comparator history tracks through reset, no false change
	always_ff @(posedge aclk)
	begin
		cmp1_last <= comparator1_out;
		cmp2_last <= comparator2_out;
	end

	assign cmp1_chg = comparator1_out ^ cmp1_last;
	assign cmp2_chg = comparator2_out ^ cmp2_last;
	// low-voltage direction is applied by the detector that drives the event
	assign pf2_evt = {osc_fail, cmp1_chg, cmp2_chg, nv_write_done,
		sync_port1_collision, low_voltage_event, timer3_overflow, capcomp2_event};
	assign pf1_evt = {1'b0, conversion_done, 2'b00, sync_port1_done,
		capcomp1_event, timer2_match, timer1_overflow};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pf1_reg <= 8'h00;
			pf2_reg <= 8'h00;
		end
		else
		begin
			pf1_reg <= ((wr_pf1 ? (wbyte & MASK_PF1) : (pf1_reg & MASK_PF1)) | pf1_evt)
				| {2'b00, serial1_rx_full, serial1_tx_empty, 4'h0};
			pf2_reg <= (wr_pf2 ? wbyte : pf2_reg) | pf2_evt;
		end
	end

	// peripheral enables and priorities live outside this block: all enabled, low
	assign pie1 = 8'h7F;
	assign pie2 = 8'hFF;

	// ---- request combining
	always_comb
	begin
		hi_src = (main_reg[B_X0_EN] && main_reg[B_X0_FLAG])
			|| (main_reg[B_T0_EN] && main_reg[B_T0_FLAG] && edges_reg[B_T0_PRIO])
			|| (main_reg[B_PC_EN] && main_reg[B_PC_FLAG] && pc_enabled
				&& edges_reg[B_PC_PRIO])
			|| (ext_reg[B_X1_EN] && ext_reg[B_X1_FLAG] && ext_reg[B_X1_PRIO])
			|| (ext_reg[B_X2_EN] && ext_reg[B_X2_FLAG] && ext_reg[B_X2_PRIO]);
		periph_pend = |(pf1_reg & pie1) || |(pf2_reg & pie2);
		lo_src = (main_reg[B_T0_EN] && main_reg[B_T0_FLAG] && !edges_reg[B_T0_PRIO])
			|| (main_reg[B_PC_EN] && main_reg[B_PC_FLAG] && pc_enabled
				&& !edges_reg[B_PC_PRIO])
			|| (ext_reg[B_X1_EN] && ext_reg[B_X1_FLAG] && !ext_reg[B_X1_PRIO])
			|| (ext_reg[B_X2_EN] && ext_reg[B_X2_FLAG] && !ext_reg[B_X2_PRIO])
			|| periph_pend;
		core_pend = (main_reg[B_X0_EN] && main_reg[B_X0_FLAG])
			|| (main_reg[B_T0_EN] && main_reg[B_T0_FLAG])
			|| (main_reg[B_PC_EN] && main_reg[B_PC_FLAG] && pc_enabled)
			|| (ext_reg[B_X1_EN] && ext_reg[B_X1_FLAG])
			|| (ext_reg[B_X2_EN] && ext_reg[B_X2_FLAG]);
		compat_req = global_high_enable
			&& (core_pend || (peripheral_low_enable && periph_pend));
		if (priority_mode_enable)
		begin
			next_irq_high = global_high_enable && hi_src;
			next_irq_low  = global_high_enable && peripheral_low_enable && lo_src
				&& !in_high;
		end
		else
		begin
			next_irq_high = compat_req;
			next_irq_low  = 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_high        <= 1'b0;
			irq_low         <= 1'b0;
			irq_vector      <= VEC_HIGH;
			portb_pullup_on <= 8'h00;
		end
		else
		begin
			irq_high   <= next_irq_high;
			irq_low    <= next_irq_low;
			irq_vector <= (next_irq_high || !next_irq_low) ? VEC_HIGH : VEC_LOW;
			portb_pullup_on <= edges_reg[B_PU_DIS] ? 8'h00
				: (portb_is_input & per_pin_pullup_enable);
		end
	end

	// ---- axi4-lite read, one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OK;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OK;
				if (hit_at(s_axi_araddr, OFF_MAIN))
					s_axi_rdata <= {24'h0, main_reg};
				else if (hit_at(s_axi_araddr, OFF_EDGES))
					s_axi_rdata <= {24'h0, edges_reg};
				else if (hit_at(s_axi_araddr, OFF_EXTPINS))
					s_axi_rdata <= {24'h0, ext_reg};
				else if (hit_at(s_axi_araddr, OFF_PFLAGS1))
					s_axi_rdata <= {24'h0, pf1_reg};
				else if (hit_at(s_axi_araddr, OFF_PFLAGS2))
					s_axi_rdata <= {24'h0, pf2_reg};
				else if (hit_at(s_axi_araddr, OFF_CONFIG))
					s_axi_rdata <= {8'h0, per_pin_pullup_enable, 4'h0,
						per_pin_change_enable, 7'h0, priority_mode_enable};
				else if (hit_at(s_axi_araddr, OFF_STATUS))
					s_axi_rdata <= {28'h0, in_high, in_low, irq_high, irq_low};
				else
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ---- checks
	t0_flag_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
		timer0_overflow |=> main_reg[B_T0_FLAG]) else $error("timer0 flag missed");
	ghigh_blocks_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!global_high_enable |=> !irq_high && !irq_low) else $error("request while off");
	low_needs_both_a: assert property (@(posedge aclk) disable iff (!aresetn)
		irq_low |-> $past(peripheral_low_enable) && $past(priority_mode_enable))
		else $error("low without enables");
	compat_no_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(!priority_mode_enable) |-> !irq_low) else $error("low in compat");
	x0_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
		priority_mode_enable && global_high_enable && main_reg[B_X0_EN] && main_reg[B_X0_FLAG]
		|=> irq_high) else $error("ext0 not high");
	ack_clears_a: assert property (@(posedge aclk) disable iff (!aresetn)
		irq_ack_high && !irq_return |=> !global_high_enable) else $error("ack kept enable");
	rx_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		serial1_rx_full |=> pf1_reg[B_RX_FULL]) else $error("rx flag low");
	pullup_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		edges_reg[B_PU_DIS] |=> portb_pullup_on == 8'h00) else $error("pull-up on");
	vec_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
		irq_low && !irq_high |-> irq_vector == VEC_LOW) else $error("wrong vector");
endmodule

// ==== sim/core_model.sv ====
// behavioural processor core that takes and answers interrupt requests
module core_model
(
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// requests and bench controls
	input  wire logic       irq_high,
	input  wire logic       irq_low,
	input  wire logic [3:0] delay,
	input  wire logic       done,
	// answers
	output logic            ack_high,
	output logic            ack_low,
	output logic            ret
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	logic       busy;
	// a slow answer leaves the global bits alone while a request waits
	always_ff @(posedge aclk)
	begin
		ack_high <= 1'b0;
		ack_low <= 1'b0;
		ret <= 1'b0;
		if (!aresetn)
		begin
			cnt <= 4'h0;
			busy <= 1'b0;
		end
		else if (busy)
		begin
			ret <= done;
			busy <= !done;
		end
		else if (irq_high | irq_low)
		begin
			cnt <= cnt + 4'h1;
			if (cnt >= delay)
			begin
				ack_high <= irq_high;
				ack_low <= !irq_high;
				busy <= 1'b1;
				cnt <= 4'h0;
			end
		end
		else
			cnt <= 4'h0;
	end
endmodule

// ==== sim/tb_two_level_interrupt_control.sv ====
// register and request bench for the two-level interrupt control
module tb_two_level_interrupt_control
	import irq_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
	logic [3:0]  s_axi_wstrb = 4'hF, portb_upper = 4'h0, delay = 4'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [10:0] ev = 11'h000;
	logic        timer0_overflow = 1'b0, portb_read = 1'b0, done = 1'b0;
	logic        comparator1_out = 1'b0, comparator2_out = 1'b0;
	logic        serial1_rx_full = 1'b1, serial1_tx_empty = 1'b0;
	logic [2:0]  ext_pins = 3'h0;
	logic [7:0]  portb_is_input = 8'h0F, portb_pullup_on;
	logic        irq_ack_high, irq_ack_low, irq_return, irq_high, irq_low;
	logic [15:0] irq_vector;
	int          errors = 0, n_tests = 0;
	always #5 aclk = ~aclk;
	two_level_interrupt_control uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.timer0_overflow, .timer1_overflow(ev[0]), .timer2_match(ev[1]),
		.capcomp1_event(ev[2]), .sync_port1_done(ev[3]), .conversion_done(ev[4]),
		.capcomp2_event(ev[5]), .timer3_overflow(ev[6]), .low_voltage_event(ev[7]),
		.sync_port1_collision(ev[8]), .nv_write_done(ev[9]), .osc_fail(ev[10]),
		.comparator1_out, .comparator2_out, .serial1_rx_full, .serial1_tx_empty,
		.ext_pins, .portb_upper, .portb_read, .portb_is_input, .irq_ack_high,
		.irq_ack_low, .irq_return, .irq_high, .irq_low, .irq_vector, .portb_pullup_on);
	core_model core (.aclk, .aresetn, .irq_high, .irq_low, .delay, .done,
		.ack_high(irq_ack_high), .ack_low(irq_ack_low), .ret(irq_return));
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
		n_tests++;
		if (got !== e)
		begin
			errors++;
			$display("Error %s expected %h seen %h", what, e, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		rd_data = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rc(input string r, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(r, e, rd_data);
	endtask
	// waits a few edges for the expected request lines and vector;
	// one edge first, so a register write has reached the request lines
	task automatic see(input logic [1:0] hl, input logic [15:0] v);
		int i;
		i = 0;
		@(posedge aclk);
		while (i < 8 && {irq_high, irq_low, irq_vector} !== {hl, v})
		begin
			@(posedge aclk);
			i++;
		end
		chk("request", {hl, v}, {irq_high, irq_low, irq_vector});
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		#200000;
		errors++;
		finish_test();
	end
	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rc("main", OFF_MAIN, 32'h00);
		rc("edges", OFF_EDGES, 32'hF5);
		rc("extpins", OFF_EXTPINS, 32'hC0);
		rc("pflags1", OFF_PFLAGS1, 32'h20);
		rc("pflags2", OFF_PFLAGS2, 32'h00);
		rc("unmapped", 8'h1C, 32'h0);
		chk("rresp", RESP_SLVERR, resp);
		wr(8'h1C, 32'hFF);
		chk("bresp", RESP_SLVERR, resp);
		serial1_rx_full <= 1'b0;
		serial1_tx_empty <= 1'b1;
		wr(OFF_PFLAGS1, 32'hFF);
		rc("pflags1 ro", OFF_PFLAGS1, 32'h5F);
		wr(OFF_PFLAGS1, 32'h00);
		@(posedge aclk);
		ev <= 11'h7FF;
		comparator1_out <= 1'b1;
		comparator2_out <= 1'b1;
		@(posedge aclk);
		ev <= 11'h000;
		rc("pflags1 ev", OFF_PFLAGS1, 32'h5F);
		rc("pflags2 ev", OFF_PFLAGS2, 32'hFF);
		see(2'b00, VEC_HIGH);
		wr(OFF_PFLAGS1, 32'h00);
		wr(OFF_PFLAGS2, 32'h00);
		rc("pflags2 clr", OFF_PFLAGS2, 32'h00);
		@(posedge aclk);
		timer0_overflow <= 1'b1;
		ext_pins <= 3'h7;
		@(posedge aclk);
		timer0_overflow <= 1'b0;
		rc("main t0", OFF_MAIN, 32'h06);
		rc("ext rise", OFF_EXTPINS, 32'hC3);
		wr(OFF_MAIN, 32'h00);
		wr(OFF_EXTPINS, 32'hC0);
		ext_pins <= 3'h0;
		rc("ext fall", OFF_EXTPINS, 32'hC0);
		wr(OFF_EDGES, 32'h85);
		ext_pins <= 3'h7;
		rc("ext rise2", OFF_EXTPINS, 32'hC0);
		ext_pins <= 3'h0;
		rc("ext fall2", OFF_EXTPINS, 32'hC3);
		wr(OFF_EXTPINS, 32'hC0);
		wr(OFF_MAIN, 32'h08);
		portb_upper <= 4'h2;
		rc("change", OFF_MAIN, 32'h09);
		wr(OFF_MAIN, 32'h88);
		rc("mismatch", OFF_MAIN, 32'h89);
		see(2'b00, VEC_HIGH);
		wr(OFF_CONFIG, 32'h00FF0F00);
		see(2'b10, VEC_HIGH);
		rc("acked", OFF_MAIN, 32'h09);
		@(posedge aclk);
		portb_read <= 1'b1;
		@(posedge aclk);
		portb_read <= 1'b0;
		wr(OFF_MAIN, 32'h08);
		rc("read ends", OFF_MAIN, 32'h08);
		done <= 1'b1;
		@(posedge aclk);
		done <= 1'b0;
		rc("returned", OFF_MAIN, 32'h88);
		chk("pullup off", 8'h00, portb_pullup_on);
		wr(OFF_EDGES, 32'h05);
		rc("edges", OFF_EDGES, 32'h05);
		chk("pullup", 8'h0F, portb_pullup_on);
		delay <= 4'hF;
		ev <= 11'h001;
		@(posedge aclk);
		ev <= 11'h000;
		see(2'b00, VEC_HIGH);
		wr(OFF_MAIN, 32'hC8);
		repeat (8) if (!(irq_high | irq_low)) @(posedge aclk);
		chk("periph request", 1'b1, irq_high | irq_low);
		chk("compat vector", VEC_HIGH, irq_vector);
		wr(OFF_MAIN, 32'h48);
		see(2'b00, VEC_HIGH);
		wr(OFF_PFLAGS1, 32'h00);
		wr(OFF_CONFIG, 32'h00FF0F01);
		rc("config", OFF_CONFIG, 32'h00FF0F01);
		wr(OFF_EDGES, 32'h01);
		wr(OFF_MAIN, 32'hA4);
		see(2'b00, VEC_HIGH);
		wr(OFF_MAIN, 32'hE4);
		see(2'b01, VEC_LOW);
		wr(OFF_MAIN, 32'h64);
		see(2'b00, VEC_HIGH);
		wr(OFF_MAIN, 32'h90);
		ext_pins <= 3'h1;
		@(posedge aclk);
		ext_pins <= 3'h0;
		see(2'b10, VEC_HIGH);
		repeat (24) @(posedge aclk);
		rc("high taken", OFF_MAIN, 32'h12);
		rc("in service", OFF_STATUS, 32'h08);
		finish_test();
	end
endmodule
